// File: verilog/scpc_defines.svh
`ifndef SCPC_DEFINES_SVH
`define SCPC_DEFINES_SVH

// ----------------------------------------------------------------
// clock enable bits of the gate vector
// ----------------------------------------------------------------
`define SCPC_GATE_CORE 0
`define SCPC_GATE_BUS 1
`define SCPC_GATE_LOCAL_INT 2
`define SCPC_GATE_PLL 3
`define SCPC_GATE_WIDTH 4

// ----------------------------------------------------------------
// gate values per state and timing
// ----------------------------------------------------------------
`define SCPC_GATE_ALL_ON 4'h000f
`define SCPC_GATE_GRANT 4'h000e
`define SCPC_GATE_SLEEP 4'h0008
`define SCPC_GATE_DEEP 4'h0000
`define SCPC_SYNC_STAGES 2

`endif

// File: verilog/scpc_pkg.sv
package scpc_pkg;

    typedef enum logic [2:0]
    {
        SCPC_RUN,
        SCPC_ACK,
        SCPC_GRANT,
        SCPC_SLEEP,
        SCPC_DEEP
    } scpc_state_type;

    // request pins after synchronisation, active high
    typedef struct packed
    {
        logic halt;
        logic sleep;
        logic deep;
    } scpc_req_type;

    // clock enables toward the clock tree
    typedef struct packed
    {
        logic pll;
        logic local_int;
        logic bus;
        logic core;
    } scpc_gate_type;

endpackage

// File: verilog/scpc_sync.sv
`timescale 1ns/1ps
`include "scpc_defines.svh"

module scpc_sync
    import scpc_pkg::*;
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [2:0] async_in,
    output logic [2:0] sync_out
);

    logic [2:0] stage1;

    // first stage feeds only the second
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            stage1 <= 3'h0;
            sync_out <= 3'h0;
        end
        else
        begin
            stage1 <= async_in;
            sync_out <= stage1;
        end
    end

endmodule

// File: verilog/scpc_stop_clock_ctrl.sv
`timescale 1ns/1ps
`include "scpc_defines.svh"

// How it works
// (R01) a held halt-clock request moves the core from running to grant.
// (R02) entering grant from run sends one acknowledge pulse toward the bus unit.
// (R03) in grant only the core clock is gated; bus and local int run.
// (R04) in grant the snoop and interrupt service enables stay high.
// (R05) releasing the halt request in grant, with no sleep request, reopens all clocks and resumes run.
// (R06) the bus clock is gated only in sleep and deep sleep; in run, ack and grant it stays on.
// (R07) all request pins pass a two flop synchroniser before use.
// (R08) sleep request in grant enters sleep, leaving only the pll on.
// (R09) in sleep snoops and interrupts are ignored.
// (R10) sleep release returns to grant with bus and local int clocks on.
// (R11) deeper sleep request while in sleep, with the sleep request still held, enters deep sleep.
// (R12) reset puts the machine in running state, all clocks enabled.

module scpc_stop_clock_ctrl
    import scpc_pkg::*;
(
    input wire logic clock,
    input wire logic rstn,
    input wire logic halt_clock_request_n,
    input wire logic sleep_request_n,
    input wire logic deeper_sleep_request_n,
    output logic stop_grant_ack,
    output logic [`SCPC_GATE_WIDTH-1:0] clock_enable,
    output logic execute_enable,
    output logic snoop_enable,
    output logic interrupt_enable,
    output logic deep_sleep_status
);

    // ----------------------------------------------------------------
    // reset release
    // ----------------------------------------------------------------
    logic rst_meta;
    logic rst_n;

    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end
        else
        begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    // ----------------------------------------------------------------
    // request synchronisation
    // ----------------------------------------------------------------
    wire [2:0] raw_req;
    logic [2:0] sync_req;
    scpc_req_type req;

    // pins are active low; invert before the flops so reset means idle
    assign raw_req = {~halt_clock_request_n, ~sleep_request_n,
                      ~deeper_sleep_request_n};

    scpc_sync u_sync  // see (R07)
    (
        .clock(clock),
        .rst_n(rst_n),
        .async_in(raw_req),
        .sync_out(sync_req)
    );

    assign req = scpc_req_type'(sync_req);

    // ----------------------------------------------------------------
    // state machine
    // ----------------------------------------------------------------
    scpc_state_type state;
    scpc_state_type next_state;

    always_comb
    begin
        next_state = state;
        unique case (state)
            SCPC_RUN:
                if (req.halt)
                    next_state = SCPC_ACK;  // see (R01)
            SCPC_ACK:
                next_state = SCPC_GRANT;
            SCPC_GRANT:
                if (req.sleep)
                    next_state = SCPC_SLEEP;  // see (R08)
                else if (!req.halt)
                    next_state = SCPC_RUN;  // see (R05)
            SCPC_SLEEP:
                if (!req.sleep)
                    next_state = SCPC_GRANT;  // see (R10)
                else if (req.deep)
                    next_state = SCPC_DEEP;  // see (R11)
            SCPC_DEEP:
                // deep sleep leaves back into sleep once the pin rises
                if (!req.deep)
                    next_state = SCPC_SLEEP;
            default:
                next_state = SCPC_RUN;
        endcase
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            state <= SCPC_RUN;  // see (R12)
        else
            state <= next_state;
    end

    // ----------------------------------------------------------------
    // output decode
    // ----------------------------------------------------------------
    scpc_gate_type next_gate;
    wire next_ack;
    wire next_exec;
    wire next_awake;
    wire in_halt;

    assign in_halt = (next_state == SCPC_ACK) ||
                     (next_state == SCPC_GRANT);
    // core gated, bus and local int kept, pll kept: see (R03) (R06)
    assign next_gate = (next_state == SCPC_RUN) ?
                           scpc_gate_type'(`SCPC_GATE_ALL_ON) :
                       in_halt ? scpc_gate_type'(`SCPC_GATE_GRANT) :
                       (next_state == SCPC_SLEEP) ?
                           scpc_gate_type'(`SCPC_GATE_SLEEP) :
                           scpc_gate_type'(`SCPC_GATE_DEEP);
    assign next_ack = (next_state == SCPC_ACK);  // see (R02)
    assign next_exec = (next_state == SCPC_RUN);  // see (R05)
    // snoops and interrupts live in run, ack and grant only: see (R04) (R09)
    assign next_awake = next_exec || in_halt;

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            clock_enable <= `SCPC_GATE_ALL_ON;
            stop_grant_ack <= 1'b0;
            execute_enable <= 1'b1;
            snoop_enable <= 1'b1;
            interrupt_enable <= 1'b1;
            deep_sleep_status <= 1'b0;
        end
        else
        begin
            clock_enable <= next_gate;
            stop_grant_ack <= next_ack;
            execute_enable <= next_exec;
            snoop_enable <= next_awake;
            interrupt_enable <= next_awake;
            deep_sleep_status <= (next_state == SCPC_DEEP);
        end
    end

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);

    a_halt_entry: assert property (  // see (R01)
        (state == SCPC_RUN) && req.halt |=> stop_grant_ack)
        else $error("halt request not acknowledged");
    a_ack_pulse: assert property (  // see (R02)
        stop_grant_ack |=> !stop_grant_ack ##0
        !clock_enable[`SCPC_GATE_CORE])
        else $error("ack not single pulse");
    a_ack_state: assert property (  // see (R02)
        stop_grant_ack |-> state == SCPC_ACK)
        else $error("ack outside entry");
    a_grant_gate: assert property (  // see (R03)
        (state == SCPC_GRANT) |-> clock_enable == `SCPC_GATE_GRANT)
        else $error("grant gating wrong");
    a_grant_awake: assert property (  // see (R04)
        (state == SCPC_GRANT) |-> snoop_enable && interrupt_enable)
        else $error("grant lost snoop");
    a_resume_run: assert property (  // see (R05)
        (state == SCPC_GRANT) && !req.halt && !req.sleep |=>
        execute_enable && clock_enable == `SCPC_GATE_ALL_ON)
        else $error("no resume");
    a_bus_kept: assert property (  // see (R06)
        (state != SCPC_SLEEP) && (state != SCPC_DEEP) |->
        clock_enable[`SCPC_GATE_BUS])
        else $error("bus clock gated");
    // two quiet edges after the pin falls: a raw pin would ack at once
    a_sync_delay: assert property (  // see (R07)
        $fell(halt_clock_request_n) && (state == SCPC_RUN) |->
        ##1 !stop_grant_ack ##1 !stop_grant_ack)
        else $error("request not synchronised");
    a_sleep_entry: assert property (  // see (R08)
        (state == SCPC_GRANT) && req.sleep |=>
        clock_enable == `SCPC_GATE_SLEEP)
        else $error("sleep not entered");
    a_sleep_deaf: assert property (  // see (R09)
        (state == SCPC_SLEEP) |-> !snoop_enable && !interrupt_enable)
        else $error("sleep still awake");
    // a halt release alone must not wake the core out of sleep
    a_sleep_hold: assert property (  // see (R09)
        (state == SCPC_SLEEP) && req.sleep && !req.deep |=>
        clock_enable == `SCPC_GATE_SLEEP)
        else $error("sleep left early");
    a_sleep_exit: assert property (  // see (R10)
        (state == SCPC_SLEEP) && !req.sleep |=>
        state == SCPC_GRANT ##0 clock_enable == `SCPC_GATE_GRANT)
        else $error("sleep exit wrong");
    a_deep_entry: assert property (  // see (R11)
        (state == SCPC_SLEEP) && req.sleep && req.deep |=>
        deep_sleep_status)
        else $error("deep sleep not entered");
    a_deep_gate: assert property (  // see (R11)
        (state == SCPC_DEEP) |->
        clock_enable == `SCPC_GATE_DEEP && deep_sleep_status)
        else $error("deep gating wrong");
    a_run_open: assert property (  // see (R12)
        (state == SCPC_RUN) |->
        execute_enable && clock_enable == `SCPC_GATE_ALL_ON)
        else $error("run clocks not open");

    // ----------------------------------------------------------------
    // cover points
    // ----------------------------------------------------------------
    c_grant: cover property (stop_grant_ack ##1 state == SCPC_GRANT);
    c_resume: cover property ((state == SCPC_GRANT) ##1 state == SCPC_RUN);
    c_sleep: cover property ((state == SCPC_SLEEP) ##1 state == SCPC_GRANT);
    c_deep: cover property (deep_sleep_status);

endmodule

// File: verification/scpc_chipset_model.sv
`timescale 1ns/1ps

// ----------------------------------------------------------------
// chipset side: request pins, changed off the clock grid
// ----------------------------------------------------------------
module scpc_chipset_model
(
    input wire logic [2:0] want,
    output logic halt_clock_request_n,
    output logic sleep_request_n,
    output logic deeper_sleep_request_n
);
    integer seed = 32'h0000_5a17;
    logic [2:0] pins = 3'h7;

    assign halt_clock_request_n = pins[0];
    assign sleep_request_n = pins[1];
    assign deeper_sleep_request_n = pins[2];

    // random skew so a pin lands 5 to 39 ns after the clock edge
    always @(want)
    begin
        #(5 + {$random(seed)} % 35);
        pins = ~want;
    end
endmodule

// File: verification/stop_clock_power_state_control_bench.sv
`timescale 1ns/1ps

module stop_clock_power_state_control_bench;
    import scpc_pkg::*;
    logic clock = 1'h0;
    logic rstn = 1'h0;
    logic [2:0] want = 3'h0;
    logic halt_clock_request_n;
    logic sleep_request_n;
    logic deeper_sleep_request_n;
    logic stop_grant_ack;
    logic execute_enable;
    logic snoop_enable;
    logic interrupt_enable;
    logic deep_sleep_status;
    logic [3:0] clock_enable;
    logic [7:0] seen;
    logic [1:0] st;
    logic [1:0] old;
    logic [31:0] r;
    // the 3'h5 drops sleep under a held deeper request: back to grant
    logic [2:0] corner [11] = '{3'h2, 3'h1, 3'h3, 3'h5, 3'h3, 3'h7, 3'h3,
        3'h1, 3'h0, 3'h7, 3'h0};
    integer errors = 0;
    integer cmp_count = 0;
    integer seed = 32'h1ec3_6b2a;
    integer i;
    integer k;
    integer acks;

    always #25 clock = ~clock;

    assign seen = {deep_sleep_status, interrupt_enable, snoop_enable,
        execute_enable, clock_enable};

    scpc_chipset_model far_side
    (
        .want(want),
        .halt_clock_request_n(halt_clock_request_n),
        .sleep_request_n(sleep_request_n),
        .deeper_sleep_request_n(deeper_sleep_request_n)
    );

    scpc_stop_clock_ctrl dut
    (
        .clock(clock),
        .rstn(rstn),
        .halt_clock_request_n(halt_clock_request_n),
        .sleep_request_n(sleep_request_n),
        .deeper_sleep_request_n(deeper_sleep_request_n),
        .stop_grant_ack(stop_grant_ack),
        .clock_enable(clock_enable),
        .execute_enable(execute_enable),
        .snoop_enable(snoop_enable),
        .interrupt_enable(interrupt_enable),
        .deep_sleep_status(deep_sleep_status)
    );

    // ----------------------------------------------------------------
    // expectation: 0 run, 1 grant, 2 sleep, 3 deep
    // ----------------------------------------------------------------
    function automatic logic [7:0] outs(input logic [1:0] s);
        case (s)
            2'h0: outs = 8'h7f;
            2'h1: outs = 8'h6e;
            2'h2: outs = 8'h08;
            default: outs = 8'h80;
        endcase
    endfunction

    // want bits: 0 halt, 1 sleep, 2 deep; sleep beats halt release
    // leaving sleep beats a deeper request
    function automatic logic [1:0] nxt(input logic [1:0] s,
        input logic [2:0] w);
        case (s)
            2'h0: nxt = w[0] ? 2'h1 : 2'h0;
            2'h1: nxt = w[1] ? 2'h2 : (w[0] ? 2'h1 : 2'h0);
            2'h2: nxt = !w[1] ? 2'h1 : (w[2] ? 2'h3 : 2'h2);
            default: nxt = w[2] ? 2'h3 : 2'h2;
        endcase
    endfunction

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        cmp_count = cmp_count + 1;
        if (got !== exp)
        begin
            errors = errors + 1;
            $display("unexpected at %0t: got %h expected %h", $time, got,
                exp);
        end
    endtask

    // long settle window: a full run to deep chain takes about 7 edges
    task automatic step(input logic [2:0] w);
        @(posedge clock);
        old = st;
        want <= w;
        @(posedge clock);
        #1;
        check(seen, outs(old));
        acks = 0;
        repeat (10)
        begin
            @(posedge clock);
            #1;
            acks = acks + stop_grant_ack;
        end
        for (k = 0; k < 4; k++) st = nxt(st, w);
        check(seen, outs(st));
        check(seen, outs(st));
        check(8'(acks), 8'((old == 2'h0) && (st != 2'h0)));
    endtask

    task automatic summarize;
        $display("comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    initial
    begin
        st = 2'h0;
        repeat (2) @(posedge clock);
        rstn <= 1'h1;
        repeat (3) @(posedge clock);
        #1;
        check(seen, outs(2'h0));
        foreach (corner[j]) step(corner[j]);
        $display("corner sequence done");
        for (i = 0; i < 40; i++)
        begin
            r = $random(seed);
            step(r[2:0]);
        end
        $display("random sequence done");
        step(3'h7);
        @(posedge clock);
        rstn <= 1'h0;
        want <= 3'h0;
        #1;
        check(seen, outs(2'h0));
        @(posedge clock);
        rstn <= 1'h1;
        repeat (4) @(posedge clock);
        #1;
        check(seen, outs(2'h0));
        $display("reset in deep sleep done");
        summarize();
    end
endmodule
